//--- src/gcr_regs.sv
// general control register bank: control, status, jtag port, reference counter
//
// Behaviour
// - control bit 0 drives eeprom program enable
// - control bit 1 drives eeprom protect enable
// - soft reset clears receive storage, fifo, flags
// - soft reset spares mode, loopback, enables, eeprom
// - bit 2 write-only, each 1 resets
// - control bit 4 enables periodic interrupt
// - read-only firmware revision field in control
// - bits 23..16 return fixed board type
// - override 0 hardware drives led, else bits
// - led override cleared by any reset
// - bit 25 green, bit 26 red when overridden
// - status bit 4 pending every 2^21 cycles
// - writing one clears pending flag
// - unused upper status and jtag bits read zero
// - jtag word bits drive configuration memory lines
// - free-running 32-bit readable reference counter
// - time stamps taken from same counter
`timescale 1ns/10ps
module gcr_regs
    import gcr_pkg::*;
#(
    parameter int PERIOD_CYCLES = GCR_PERIODIC_IRQ_CYCLES,
    parameter logic [7:0] FIRMWARE_REVISION = GCR_FW_REV_DEFAULT,
    parameter logic [7:0] BOARD_TYPE_CODE = GCR_BOARD_TYPE_DEFAULT
)
(
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [GCR_ADDR_W-1:0] I_REG_ADDR,
    input wire logic [GCR_DATA_W-1:0] I_REG_WDATA,
    output logic [GCR_DATA_W-1:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    output logic O_EEPROM_PROGRAM_ENABLE,
    output logic O_EEPROM_PROTECT_ENABLE,
    output logic O_SOFT_RESET,
    output logic O_PERIODIC_IRQ,
    input wire logic I_HW_LED_GREEN,
    input wire logic I_HW_LED_RED,
    output logic O_LED_GREEN,
    output logic O_LED_RED,
    output logic O_CFG_TRST_N,
    output logic O_CFG_TMS,
    output logic O_CFG_TCK,
    output logic O_CFG_TDI,
    input wire logic I_CFG_TDO,
    output logic [GCR_DATA_W-1:0] O_REFERENCE_TICK_COUNT
);

    // one-hot register select
    function automatic logic sel(input logic [GCR_ADDR_W-1:0] addr,
                                 input logic [GCR_ADDR_W-1:0] ofs);
        sel = (addr == ofs);
    endfunction : sel

    logic [GCR_DATA_W-1:0] reference_tick_count;
    logic period_tick;

    // control state
    logic eeprom_program_enable_r;
    logic eeprom_program_enable_nxt;
    logic eeprom_protect_enable_r;
    logic eeprom_protect_enable_nxt;
    logic periodic_irq_enable_r;
    logic periodic_irq_enable_nxt;
    logic led_override_r;
    logic led_override_nxt;
    logic led_green_state_r;
    logic led_green_state_nxt;
    logic led_red_state_r;
    logic led_red_state_nxt;
    logic soft_reset_r;
    logic soft_reset_nxt;

    // status state
    logic periodic_irq_pending_r;
    logic periodic_irq_pending_nxt;

    // jtag port state
    logic jtag_trst_r;
    logic jtag_trst_nxt;
    logic jtag_tms_r;
    logic jtag_tms_nxt;
    logic jtag_tck_r;
    logic jtag_tck_nxt;
    logic jtag_tdi_r;
    logic jtag_tdi_nxt;

    // read path state
    logic [GCR_DATA_W-1:0] rdata_r;
    logic [GCR_DATA_W-1:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;

    logic wr_ctl;
    logic wr_sts;
    logic wr_jtg;

    gcr_ref_counter #(
        .PERIOD_CYCLES(PERIOD_CYCLES)
    ) u_ref_counter (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .o_count(reference_tick_count),
        .o_period_tick(period_tick)
    );

    assign wr_ctl = I_REG_WR && sel(I_REG_ADDR, GCR_OFS_CONTROL);
    assign wr_sts = I_REG_WR && sel(I_REG_ADDR, GCR_OFS_STATUS);
    assign wr_jtg = I_REG_WR && sel(I_REG_ADDR, GCR_OFS_JTAG);

    // control word
    always_comb
    begin
        eeprom_program_enable_nxt = eeprom_program_enable_r;
        eeprom_protect_enable_nxt = eeprom_protect_enable_r;
        periodic_irq_enable_nxt = periodic_irq_enable_r;
        led_override_nxt = led_override_r;
        led_green_state_nxt = led_green_state_r;
        led_red_state_nxt = led_red_state_r;
        soft_reset_nxt = 1'b0;
        if (wr_ctl)
        begin
            eeprom_program_enable_nxt = I_REG_WDATA[GCR_CTL_PROG_EN_BIT];
            eeprom_protect_enable_nxt = I_REG_WDATA[GCR_CTL_PROT_EN_BIT];
            periodic_irq_enable_nxt = I_REG_WDATA[GCR_CTL_PER_IRQ_EN_BIT];
            led_override_nxt = I_REG_WDATA[GCR_CTL_LED_OVR_BIT];
            led_green_state_nxt = I_REG_WDATA[GCR_CTL_LED_GREEN_BIT];
            led_red_state_nxt = I_REG_WDATA[GCR_CTL_LED_RED_BIT];
            soft_reset_nxt = I_REG_WDATA[GCR_CTL_SOFT_RST_BIT];
            // soft reset drops override, keeps eeprom and enable bits
            if (I_REG_WDATA[GCR_CTL_SOFT_RST_BIT])
            begin
                led_override_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            eeprom_program_enable_r <= GCR_RST_BIT;
            eeprom_protect_enable_r <= GCR_RST_BIT;
            periodic_irq_enable_r <= GCR_RST_BIT;
            led_override_r <= GCR_RST_BIT;
            led_green_state_r <= GCR_RST_BIT;
            led_red_state_r <= GCR_RST_BIT;
            soft_reset_r <= GCR_RST_BIT;
        end
        else
        begin
            eeprom_program_enable_r <= eeprom_program_enable_nxt;
            eeprom_protect_enable_r <= eeprom_protect_enable_nxt;
            periodic_irq_enable_r <= periodic_irq_enable_nxt;
            led_override_r <= led_override_nxt;
            led_green_state_r <= led_green_state_nxt;
            led_red_state_r <= led_red_state_nxt;
            soft_reset_r <= soft_reset_nxt;
        end
    end

    // status word: set wins over a simultaneous clear
    always_comb
    begin
        periodic_irq_pending_nxt = periodic_irq_pending_r;
        if (wr_sts && I_REG_WDATA[GCR_STS_PER_IRQ_BIT])
        begin
            periodic_irq_pending_nxt = 1'b0;
        end
        if (period_tick)
        begin
            periodic_irq_pending_nxt = 1'b1;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            periodic_irq_pending_r <= GCR_RST_BIT;
        end
        else
        begin
            periodic_irq_pending_r <= periodic_irq_pending_nxt;
        end
    end

    // jtag programming word
    always_comb
    begin
        jtag_trst_nxt = jtag_trst_r;
        jtag_tms_nxt = jtag_tms_r;
        jtag_tck_nxt = jtag_tck_r;
        jtag_tdi_nxt = jtag_tdi_r;
        if (wr_jtg)
        begin
            jtag_trst_nxt = I_REG_WDATA[GCR_JTG_TRST_BIT];
            jtag_tms_nxt = I_REG_WDATA[GCR_JTG_TMS_BIT];
            jtag_tck_nxt = I_REG_WDATA[GCR_JTG_TCK_BIT];
            jtag_tdi_nxt = I_REG_WDATA[GCR_JTG_TDI_BIT];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            jtag_trst_r <= GCR_RST_TRST_N;
            jtag_tms_r <= GCR_RST_BIT;
            jtag_tck_r <= GCR_RST_BIT;
            jtag_tdi_r <= GCR_RST_BIT;
        end
        else
        begin
            jtag_trst_r <= jtag_trst_nxt;
            jtag_tms_r <= jtag_tms_nxt;
            jtag_tck_r <= jtag_tck_nxt;
            jtag_tdi_r <= jtag_tdi_nxt;
        end
    end

    // read path, data one cycle after the strobe
    always_comb
    begin
        rdata_nxt = rdata_r;
        rvalid_nxt = I_REG_RD;
        if (I_REG_RD)
        begin
            rdata_nxt = GCR_RST_WORD;
            unique case (I_REG_ADDR)
                GCR_OFS_CONTROL:
                begin
                    rdata_nxt[GCR_CTL_PROG_EN_BIT] = eeprom_program_enable_r;
                    rdata_nxt[GCR_CTL_PROT_EN_BIT] = eeprom_protect_enable_r;
                    rdata_nxt[GCR_CTL_PER_IRQ_EN_BIT] = periodic_irq_enable_r;
                    rdata_nxt[GCR_CTL_FW_REV_MSB:GCR_CTL_FW_REV_LSB] =
                        FIRMWARE_REVISION;
                    rdata_nxt[GCR_CTL_TYPE_MSB:GCR_CTL_TYPE_LSB] =
                        BOARD_TYPE_CODE;
                    rdata_nxt[GCR_CTL_LED_OVR_BIT] = led_override_r;
                    rdata_nxt[GCR_CTL_LED_GREEN_BIT] = led_green_state_r;
                    rdata_nxt[GCR_CTL_LED_RED_BIT] = led_red_state_r;
                end
                GCR_OFS_STATUS:
                begin
                    rdata_nxt[GCR_STS_PER_IRQ_BIT] = periodic_irq_pending_r;
                end
                GCR_OFS_JTAG:
                begin
                    rdata_nxt[GCR_JTG_TRST_BIT] = jtag_trst_r;
                    rdata_nxt[GCR_JTG_TDO_BIT] = I_CFG_TDO;
                    rdata_nxt[GCR_JTG_TCK_BIT] = jtag_tck_r;
                    rdata_nxt[GCR_JTG_TDI_BIT] = jtag_tdi_r;
                    rdata_nxt[GCR_JTG_PEND_BIT] = periodic_irq_pending_r;
                end
                GCR_OFS_REFCNT:
                begin
                    rdata_nxt = reference_tick_count;
                end
                default:
                begin
                    rdata_nxt = GCR_RST_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            rdata_r <= GCR_RST_WORD;
            rvalid_r <= GCR_RST_BIT;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign O_REG_RDATA = rdata_r;
    assign O_REG_RVALID = rvalid_r;
    assign O_EEPROM_PROGRAM_ENABLE = eeprom_program_enable_r;
    assign O_EEPROM_PROTECT_ENABLE = eeprom_protect_enable_r;
    // receive channel clears storage, fifo, load, flags, fsms
    assign O_SOFT_RESET = soft_reset_r;
    assign O_PERIODIC_IRQ = periodic_irq_pending_r && periodic_irq_enable_r;
    assign O_LED_GREEN = led_override_r ? led_green_state_r : I_HW_LED_GREEN;
    assign O_LED_RED = led_override_r ? led_red_state_r : I_HW_LED_RED;
    assign O_CFG_TRST_N = jtag_trst_r;
    assign O_CFG_TMS = jtag_tms_r;
    assign O_CFG_TCK = jtag_tck_r;
    assign O_CFG_TDI = jtag_tdi_r;
    // time stamp source for the receive channel
    assign O_REFERENCE_TICK_COUNT = reference_tick_count;

endmodule : gcr_regs

//--- src/gcr_pkg.sv
// constants and field layout of the general control register bank
package gcr_pkg;

    localparam int GCR_DATA_W = 32;
    localparam int GCR_ADDR_W = 4;

    // register byte offsets
    localparam logic [GCR_ADDR_W-1:0] GCR_OFS_CONTROL = 4'h0;
    localparam logic [GCR_ADDR_W-1:0] GCR_OFS_STATUS = 4'h4;
    localparam logic [GCR_ADDR_W-1:0] GCR_OFS_JTAG = 4'h8;
    localparam logic [GCR_ADDR_W-1:0] GCR_OFS_REFCNT = 4'hC;

    // general control fields
    localparam int GCR_CTL_PROG_EN_BIT = 0;
    localparam int GCR_CTL_PROT_EN_BIT = 1;
    localparam int GCR_CTL_SOFT_RST_BIT = 2;
    localparam int GCR_CTL_PER_IRQ_EN_BIT = 4;
    localparam int GCR_CTL_FW_REV_LSB = 8;
    localparam int GCR_CTL_FW_REV_MSB = 15;
    localparam int GCR_CTL_TYPE_LSB = 16;
    localparam int GCR_CTL_TYPE_MSB = 23;
    localparam int GCR_CTL_LED_OVR_BIT = 24;
    localparam int GCR_CTL_LED_GREEN_BIT = 25;
    localparam int GCR_CTL_LED_RED_BIT = 26;

    // general status fields
    localparam int GCR_STS_PER_IRQ_BIT = 4;

    // jtag programming port fields
    localparam int GCR_JTG_TRST_BIT = 0;
    localparam int GCR_JTG_TDO_BIT = 1;
    localparam int GCR_JTG_TMS_BIT = 2;
    localparam int GCR_JTG_TCK_BIT = 3;
    localparam int GCR_JTG_TDI_BIT = 4;
    localparam int GCR_JTG_PEND_BIT = 5;

    // reset values
    localparam logic GCR_RST_BIT = 1'b0;
    localparam logic GCR_RST_TRST_N = 1'b0;
    localparam logic [GCR_DATA_W-1:0] GCR_RST_WORD = 32'h0000_0000;

    // field values
    localparam logic [7:0] GCR_FW_REV_DEFAULT = 8'h01;
    // arbitrary neutral board code
    localparam logic [7:0] GCR_BOARD_TYPE_DEFAULT = 8'h5A;

    // periodic interrupt spacing in reference clock cycles (2^21)
    localparam int GCR_PERIODIC_IRQ_CYCLES = 2097152;
    localparam int GCR_PERIOD_CNT_W = 22;

    localparam logic [GCR_DATA_W-1:0] GCR_ONE_WORD = 32'h0000_0001;
    localparam logic [GCR_PERIOD_CNT_W-1:0] GCR_PERIOD_ONE = 22'h00_0001;
    localparam logic [GCR_PERIOD_CNT_W-1:0] GCR_PERIOD_ZERO = 22'h00_0000;

endpackage : gcr_pkg

//--- src/gcr_ref_counter.sv
// free-running reference tick counter with periodic tick generator
`timescale 1ns/10ps
module gcr_ref_counter
    import gcr_pkg::*;
#(
    parameter int PERIOD_CYCLES = GCR_PERIODIC_IRQ_CYCLES
)
(
    input wire logic i_clk,
    input wire logic i_rstn,
    output logic [GCR_DATA_W-1:0] o_count,
    output logic o_period_tick
);

    logic [GCR_DATA_W-1:0] count_r;
    logic [GCR_DATA_W-1:0] count_nxt;
    logic [GCR_PERIOD_CNT_W-1:0] period_r;
    logic [GCR_PERIOD_CNT_W-1:0] period_nxt;
    logic tick_r;
    logic tick_nxt;

    localparam logic [GCR_PERIOD_CNT_W-1:0] PERIOD_LAST =
        GCR_PERIOD_CNT_W'(PERIOD_CYCLES - 1);

    always_comb
    begin
        count_nxt = count_r + GCR_ONE_WORD;
        tick_nxt = 1'b0;
        if (period_r == PERIOD_LAST)
        begin
            period_nxt = GCR_PERIOD_ZERO;
            tick_nxt = 1'b1;
        end
        else
        begin
            period_nxt = period_r + GCR_PERIOD_ONE;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            count_r <= GCR_RST_WORD;
            period_r <= GCR_PERIOD_ZERO;
            tick_r <= GCR_RST_BIT;
        end
        else
        begin
            count_r <= count_nxt;
            period_r <= period_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign o_count = count_r;
    assign o_period_tick = tick_r;

endmodule : gcr_ref_counter

//--- sim/gcr_properties.sv
// concurrent checks on the general control register bank ports
`timescale 1ns/10ps
module gcr_properties
    import gcr_pkg::*;
#(
    parameter logic [7:0] BOARD_TYPE_CODE = GCR_BOARD_TYPE_DEFAULT
)
(
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [GCR_ADDR_W-1:0] I_REG_ADDR,
    input wire logic [GCR_DATA_W-1:0] I_REG_WDATA,
    input wire logic [GCR_DATA_W-1:0] O_REG_RDATA,
    input wire logic O_REG_RVALID,
    input wire logic O_EEPROM_PROGRAM_ENABLE,
    input wire logic O_EEPROM_PROTECT_ENABLE,
    input wire logic O_SOFT_RESET,
    input wire logic O_PERIODIC_IRQ,
    input wire logic I_HW_LED_GREEN,
    input wire logic O_LED_GREEN,
    input wire logic O_CFG_TRST_N,
    input wire logic O_CFG_TMS,
    input wire logic O_CFG_TCK,
    input wire logic O_CFG_TDI,
    input wire logic [GCR_DATA_W-1:0] O_REFERENCE_TICK_COUNT
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RSTN);

    logic ctl_wr;
    assign ctl_wr = I_REG_WR && (I_REG_ADDR == GCR_OFS_CONTROL);

    // soft reset pulse lands with led override already dropped
    sequence s_srst_done;
        O_SOFT_RESET ##0 (O_LED_GREEN == I_HW_LED_GREEN);
    endsequence
    sequence s_ctl_rd;
        I_REG_RD ##0 (I_REG_ADDR == GCR_OFS_CONTROL);
    endsequence

    property p_pe;
        ctl_wr |=> {O_EEPROM_PROTECT_ENABLE, O_EEPROM_PROGRAM_ENABLE} == $past(I_REG_WDATA[1:0]);
    endproperty
    property p_keep;
        !ctl_wr |=> $stable({O_EEPROM_PROTECT_ENABLE, O_EEPROM_PROGRAM_ENABLE});
    endproperty
    property p_srst;
        ctl_wr && I_REG_WDATA[GCR_CTL_SOFT_RST_BIT] |=> s_srst_done;
    endproperty
    property p_nosrst;
        !(ctl_wr && I_REG_WDATA[GCR_CTL_SOFT_RST_BIT]) |=> !O_SOFT_RESET;
    endproperty
    property p_irqoff;
        ctl_wr && !I_REG_WDATA[GCR_CTL_PER_IRQ_EN_BIT] |=> !O_PERIODIC_IRQ;
    endproperty
    property p_rvalid;
        I_REG_RD |=> O_REG_RVALID;
    endproperty
    property p_ctlrd;
        s_ctl_rd |=> O_REG_RDATA[23:16] == BOARD_TYPE_CODE && O_REG_RDATA[7:5] == 3'h0
            && O_REG_RDATA[3:2] == 2'h0 && O_REG_RDATA[31:27] == 5'h00;
    endproperty
    property p_strd;
        I_REG_RD && I_REG_ADDR == GCR_OFS_STATUS |=> O_REG_RDATA[31:5] == 27'h0000000;
    endproperty
    property p_cnt;
        $past(I_RSTN) |-> O_REFERENCE_TICK_COUNT == $past(O_REFERENCE_TICK_COUNT) + GCR_ONE_WORD;
    endproperty
    property p_jtag;
        I_REG_WR && I_REG_ADDR == GCR_OFS_JTAG |=> {O_CFG_TDI, O_CFG_TCK, O_CFG_TMS, O_CFG_TRST_N}
            == {$past(I_REG_WDATA[4:2]), $past(I_REG_WDATA[0])};
    endproperty

    a_pe: assert property (p_pe) else $error("eeprom enables not taken");
    a_keep: assert property (p_keep) else $error("eeprom enables moved");
    a_srst: assert property (p_srst) else $error("soft reset pulse missing");
    a_nosrst: assert property (p_nosrst) else $error("spurious soft reset");
    a_irqoff: assert property (p_irqoff) else $error("irq while disabled");
    a_rvalid: assert property (p_rvalid) else $error("read answer missing");
    a_ctlrd: assert property (p_ctlrd) else $error("control fixed fields wrong");
    a_strd: assert property (p_strd) else $error("status upper bits set");
    a_cnt: assert property (p_cnt) else $error("tick counter not stepping");
    a_jtag: assert property (p_jtag) else $error("jtag lines wrong");
endmodule : gcr_properties

bind gcr_regs gcr_properties #(.BOARD_TYPE_CODE(BOARD_TYPE_CODE)) u_props (.*);

//--- sim/gcr_cfg_mem_model.sv
// configuration memory jtag model: shifts data in to data out on clock
`timescale 1ns/10ps
module gcr_cfg_mem_model
(
    input wire logic i_trst_n,
    input wire logic i_tck,
    input wire logic i_tdi,
    output logic o_tdo = 1'b0
);
    // data out follows data in, cleared by test reset
    always @(posedge i_tck or negedge i_trst_n)
    begin
        if (!i_trst_n)
            o_tdo <= 1'b0;
        else
            o_tdo <= i_tdi;
    end
endmodule : gcr_cfg_mem_model

//--- sim/gcr_tb.sv
// self-checking bench for the general control register bank
`timescale 1ns/10ps
module testbench
    import gcr_pkg::*;
;
    logic I_CLK = 1'b0;
    logic I_RSTN = 1'b0;
    logic I_REG_WR = 1'b0;
    logic I_REG_RD = 1'b0;
    logic [GCR_ADDR_W-1:0] I_REG_ADDR = 4'h0;
    logic [GCR_DATA_W-1:0] I_REG_WDATA = 32'h0000_0000;
    logic I_HW_LED_GREEN = 1'b0;
    logic I_HW_LED_RED = 1'b0;
    logic I_CFG_TDO;
    logic [GCR_DATA_W-1:0] O_REG_RDATA;
    logic [GCR_DATA_W-1:0] O_REFERENCE_TICK_COUNT;
    logic O_REG_RVALID, O_EEPROM_PROGRAM_ENABLE, O_EEPROM_PROTECT_ENABLE, O_SOFT_RESET;
    logic O_PERIODIC_IRQ, O_LED_GREEN, O_LED_RED, O_CFG_TRST_N, O_CFG_TMS, O_CFG_TCK, O_CFG_TDI;
    int error_cnt = 0;
    int comparisons = 0;
    localparam logic [31:0] RO_FIELDS = {8'h00, GCR_BOARD_TYPE_DEFAULT, GCR_FW_REV_DEFAULT, 8'h00};

    gcr_regs #(.PERIOD_CYCLES(16)) dut (.*);
    gcr_cfg_mem_model u_mem (.i_trst_n(O_CFG_TRST_N), .i_tck(O_CFG_TCK), .i_tdi(O_CFG_TDI),
        .o_tdo(I_CFG_TDO));

    always #12.5 I_CLK = ~I_CLK;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(negedge I_CLK);
        I_REG_WR = 1'b1;
        I_REG_ADDR = a;
        I_REG_WDATA = d;
        @(negedge I_CLK);
        I_REG_WR = 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, output logic [31:0] d);
        @(negedge I_CLK);
        I_REG_RD = 1'b1;
        I_REG_ADDR = a;
        @(negedge I_CLK);
        I_REG_RD = 1'b0;
        check(O_REG_RVALID, 32'h1);
        d = O_REG_RDATA;
    endtask : rd

    task t_reset;
        logic [31:0] d;
        rd(GCR_OFS_CONTROL, d);
        check(d, RO_FIELDS);
        rd(GCR_OFS_STATUS, d);
        check(d, 32'h0000_0000);
        rd(GCR_OFS_JTAG, d);
        check(d, 32'h0000_0000);
        I_HW_LED_GREEN = 1'b1;
        I_HW_LED_RED = 1'b1;
        @(negedge I_CLK);
        check({O_LED_RED, O_LED_GREEN}, 32'h3);
    endtask : t_reset

    task t_ctl;
        logic [31:0] d;
        I_HW_LED_GREEN = 1'b0;
        I_HW_LED_RED = 1'b0;
        wr(GCR_OFS_CONTROL, 32'hFFFF_FFFB);
        check({O_EEPROM_PROTECT_ENABLE, O_EEPROM_PROGRAM_ENABLE}, 32'h3);
        check({O_LED_RED, O_LED_GREEN}, 32'h3);
        rd(GCR_OFS_CONTROL, d);
        check(d, RO_FIELDS | 32'h0700_0013);
        wr(4'h1, 32'hFFFF_FFFF);
        rd(GCR_OFS_CONTROL, d);
        check(d, RO_FIELDS | 32'h0700_0013);
        rd(4'h1, d);
        check(d, 32'h0000_0000);
    endtask : t_ctl

    task t_soft;
        logic [31:0] d;
        I_HW_LED_GREEN = 1'b1;
        repeat (2)
        begin
            wr(GCR_OFS_CONTROL, 32'h0700_0017);
            check(O_SOFT_RESET, 32'h1);
            check({O_LED_RED, O_LED_GREEN}, 32'h1);
            @(negedge I_CLK);
            check(O_SOFT_RESET, 32'h0);
        end
        check({O_EEPROM_PROTECT_ENABLE, O_EEPROM_PROGRAM_ENABLE}, 32'h3);
        rd(GCR_OFS_CONTROL, d);
        check(d, RO_FIELDS | 32'h0600_0013);
    endtask : t_soft

    task t_periodic;
        logic [31:0] d;
        int n;
        // drop a pending flag left from earlier scenarios, then catch a fresh rise
        wr(GCR_OFS_STATUS, 32'h0000_0010);
        check(O_PERIODIC_IRQ, 32'h0);
        n = 0;
        while (O_PERIODIC_IRQ !== 1'b1 && n < 40)
        begin
            @(negedge I_CLK);
            n++;
        end
        wr(GCR_OFS_STATUS, 32'h0000_0010);
        check(O_PERIODIC_IRQ, 32'h0);
        n = 2;
        while (O_PERIODIC_IRQ !== 1'b1 && n < 40)
        begin
            @(negedge I_CLK);
            n++;
        end
        check(n, 32'd16);
        rd(GCR_OFS_STATUS, d);
        check(d, 32'h0000_0010);
        wr(GCR_OFS_CONTROL, 32'h0000_0003);
        repeat (20) @(negedge I_CLK);
        check(O_PERIODIC_IRQ, 32'h0);
        rd(GCR_OFS_STATUS, d);
        check(d, 32'h0000_0010);
    endtask : t_periodic

    task t_jtag;
        logic [31:0] d;
        wr(GCR_OFS_JTAG, 32'hFFFF_FFF5);
        check({O_CFG_TDI, O_CFG_TCK, O_CFG_TMS, O_CFG_TRST_N}, 32'hB);
        wr(GCR_OFS_JTAG, 32'h0000_0019);
        rd(GCR_OFS_JTAG, d);
        check(d & 32'hFFFF_FFDF, 32'h0000_001B);
        wr(GCR_OFS_JTAG, 32'h0000_0000);
        rd(GCR_OFS_JTAG, d);
        check(d & 32'hFFFF_FFDF, 32'h0000_0000);
    endtask : t_jtag

    task t_counter;
        logic [31:0] a;
        logic [31:0] b;
        rd(GCR_OFS_REFCNT, a);
        rd(GCR_OFS_REFCNT, b);
        check(b - a, 32'h0000_0002);
        check(O_REFERENCE_TICK_COUNT - b, 32'h0000_0001);
    endtask : t_counter

    task t_hwreset;
        logic [31:0] d;
        I_HW_LED_GREEN = 1'b0;
        I_HW_LED_RED = 1'b0;
        wr(GCR_OFS_CONTROL, 32'h0300_0000);
        check({O_LED_RED, O_LED_GREEN}, 32'h1);
        I_RSTN = 1'b0;
        @(negedge I_CLK);
        check({O_LED_RED, O_LED_GREEN}, 32'h0);
        check(O_REFERENCE_TICK_COUNT, 32'h0000_0000);
        repeat (2) @(negedge I_CLK);
        I_RSTN = 1'b1;
        rd(GCR_OFS_CONTROL, d);
        check(d, RO_FIELDS);
    endtask : t_hwreset

    task finish_test;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    initial
    begin
        repeat (10) @(negedge I_CLK);
        I_RSTN = 1'b1;
        t_reset();
        t_ctl();
        t_soft();
        t_periodic();
        t_jtag();
        t_counter();
        t_hwreset();
        finish_test();
    end

    // cut a hang short well past the expected run length
    initial
    begin
        #50000;
        error_cnt++;
        finish_test();
    end
endmodule : testbench
